//--- fec_sync_status_defs.svh
// offsets, field positions and reset values of the fec status bank
`ifndef FEC_SYNC_STATUS_DEFS_SVH
`define FEC_SYNC_STATUS_DEFS_SVH

// register indices; byte address is four times the index
`define FEC_LOCK_STATUS_IDX         8'h41
`define SEG_ERR_LOW_IDX             8'h43
`define SEG_ERR_HIGH_IDX            8'h44
`define DEFRAMER_FRAME_ERR_IDX      8'h45
`define UPDATE_CTRL_IDX             8'h25
`define IRQ_STATUS_IDX              8'h60
`define IRQ_MASK_IDX                8'h61

// field positions
`define SYNC_STATE_LSB              0
`define DEINT_WORD_LSB              2
`define TRELLIS_STATE_LSB           6
`define SEG_HIGH_LSB                4
`define DEFRAMER_LOCK_BIT           4
`define FRAME_ERR_MAX_LSB           0
`define UPDATE_BIT                  0

// interrupt status bit positions
`define IRQ_SYNC_LOCK_BIT           0
`define IRQ_SYNC_LOST_BIT           1
`define IRQ_DEFRAMER_LOCK_BIT       2
`define IRQ_SNAPSHOT_BIT            3
`define IRQ_WIDTH                   4

// reset values
`define SNAPSHOT_RESET              12'h000
`define IRQ_RESET                   4'h0
`endif

//--- fec_sync_status_pkg.sv
// types shared by the fec status bank
package fec_sync_status_pkg;

    typedef enum logic [1:0] {
        SYNC_SEARCHING = 2'h0,
        SYNC_LOCKED    = 2'h1,
        SYNC_UNUSED    = 2'h2,
        SYNC_LOST      = 2'h3
    } sync_state_t;

    typedef enum logic [1:0] {
        TRELLIS_LOCKED_LOW  = 2'h0,
        TRELLIS_UNUSED      = 2'h1,
        TRELLIS_LOCKED_HIGH = 2'h2,
        TRELLIS_HUNTING     = 2'h3
    } trellis_state_t;

    typedef enum logic {
        MODE_VSB = 1'b0,
        MODE_QAM = 1'b1
    } demod_mode_t;

    // bus slave states, gray along idle -> ack -> idle
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_t;

endpackage : fec_sync_status_pkg

//--- seg_error_snapshot.sv
// held copy of the segment error count, refreshed on host request
`timescale 1ns/1ps
`include "fec_sync_status_defs.svh"

module seg_error_snapshot #(
    parameter int COUNT_W = 12
) (
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               ce_i,
    input  wire logic               update_i,
    input  wire logic [COUNT_W-1:0] live_count_i,
    output logic      [COUNT_W-1:0] held_count_o,
    output logic                    taken_o
);

    logic [COUNT_W-1:0] next_held;
    logic               next_taken;

    // ---------------------------------------------------------------
    // snapshot
    // ---------------------------------------------------------------
    always_comb begin
        next_held  = held_count_o;
        next_taken = 1'b0;
        if (update_i) begin
            next_held  = live_count_i;
            next_taken = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_count_o <= COUNT_W'(`SNAPSHOT_RESET);
            taken_o      <= 1'b0;
        end else if (ce_i) begin
            held_count_o <= next_held;
            taken_o      <= next_taken;
        end
    end

endmodule : seg_error_snapshot

//--- fec_sync_status_readout.sv
// wishbone status bank of the fec stage: lock, counts, frame errors
`timescale 1ns/1ps
`include "fec_sync_status_defs.svh"


module fec_sync_status_readout #(
    parameter int COUNT_W = 12
) (
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               ce_i,
    // wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [9:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    // status from the fec path
    input  wire logic               demod_mode_i,
    input  wire logic [1:0]         sync_state_i,
    input  wire logic [1:0]         trellis_state_i,
    input  wire logic [3:0]         deint_word_i,
    input  wire logic [COUNT_W-1:0] seg_error_count_i,
    input  wire logic               deframer_lock_i,
    input  wire logic [3:0]         frame_err_max_i,
    output logic                    irq_o
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic [7:0]                      idx;
    logic                            req;
    logic                            hit;
    logic                            update_wr;
    fec_sync_status_pkg::bus_state_t bus_state;
    fec_sync_status_pkg::bus_state_t next_bus_state;
    logic [31:0]                     next_dat;
    logic                            next_err;
    logic [7:0]                      rd_byte;
    logic [COUNT_W-1:0]              held_count;
    logic                            snap_taken;
    logic                            qam;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && (bus_state == fec_sync_status_pkg::BUS_IDLE);
    assign qam = (demod_mode_i == fec_sync_status_pkg::MODE_QAM);

    always_comb begin
        case (idx)
            `FEC_LOCK_STATUS_IDX,
            `SEG_ERR_LOW_IDX,
            `SEG_ERR_HIGH_IDX,
            `DEFRAMER_FRAME_ERR_IDX,
            `UPDATE_CTRL_IDX,
            `IRQ_STATUS_IDX,
            `IRQ_MASK_IDX: hit = 1'b1;
            default:       hit = 1'b0;
        endcase
    end

    assign update_wr = req && wb_we_i && wb_sel_i[0] && (idx == `UPDATE_CTRL_IDX)
                       && wb_dat_i[`UPDATE_BIT];

    seg_error_snapshot #(
        .COUNT_W(COUNT_W)
    ) u_snapshot (
        .clk_i       (clk_i),
        .rst_b_i     (rst_n),
        .ce_i        (ce_i),
        .update_i    (update_wr),
        .live_count_i(seg_error_count_i),
        .held_count_o(held_count),
        .taken_o     (snap_taken)
    );

    // ---------------------------------------------------------------
    // interrupt events
    // ---------------------------------------------------------------
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic [`IRQ_WIDTH-1:0] next_irq_status;
    logic [`IRQ_WIDTH-1:0] next_irq_mask;
    logic [`IRQ_WIDTH-1:0] events;
    logic [1:0]            sync_prev;
    logic                  deframer_prev;
    logic [1:0]            next_sync_prev;
    logic                  next_deframer_prev;
    logic [`IRQ_WIDTH-1:0] w1c;

    always_comb begin
        events = '0;
        events[`IRQ_SYNC_LOCK_BIT] = (sync_state_i == fec_sync_status_pkg::SYNC_LOCKED)
                                     && (sync_prev != fec_sync_status_pkg::SYNC_LOCKED);
        events[`IRQ_SYNC_LOST_BIT] = (sync_state_i == fec_sync_status_pkg::SYNC_LOST)
                                     && (sync_prev != fec_sync_status_pkg::SYNC_LOST);
        events[`IRQ_DEFRAMER_LOCK_BIT] = qam && deframer_lock_i && !deframer_prev;
        events[`IRQ_SNAPSHOT_BIT]      = snap_taken;
    end

    always_comb begin
        w1c = '0;
        if (req && wb_we_i && wb_sel_i[0] && (idx == `IRQ_STATUS_IDX)) begin
            w1c = wb_dat_i[`IRQ_WIDTH-1:0];
        end
        next_irq_mask = irq_mask;
        if (req && wb_we_i && wb_sel_i[0] && (idx == `IRQ_MASK_IDX)) begin
            next_irq_mask = wb_dat_i[`IRQ_WIDTH-1:0];
        end
        // set wins over a clear in the same cycle
        next_irq_status    = (irq_status & ~w1c) | events;
        next_sync_prev     = sync_state_i;
        next_deframer_prev = deframer_lock_i;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_status    <= `IRQ_RESET;
            irq_mask      <= `IRQ_RESET;
            sync_prev     <= 2'h0;
            deframer_prev <= 1'b0;
        end else if (ce_i) begin
            irq_status    <= next_irq_status;
            irq_mask      <= next_irq_mask;
            sync_prev     <= next_sync_prev;
            deframer_prev <= next_deframer_prev;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            `FEC_LOCK_STATUS_IDX: begin
                rd_byte[`SYNC_STATE_LSB +: 2] = sync_state_i;
                if (qam) begin
                    rd_byte[`TRELLIS_STATE_LSB +: 2] = trellis_state_i;
                    rd_byte[`DEINT_WORD_LSB +: 4] = deint_word_i;
                end
            end
            `SEG_ERR_LOW_IDX: rd_byte = held_count[7:0];
            `SEG_ERR_HIGH_IDX: begin
                // count high nibble; low nibble reserved
                rd_byte[`SEG_HIGH_LSB +: 4] = held_count[COUNT_W-1 -: 4];
            end
            `DEFRAMER_FRAME_ERR_IDX: begin
                if (qam) begin
                    rd_byte[`DEFRAMER_LOCK_BIT] = deframer_lock_i;
                    rd_byte[`FRAME_ERR_MAX_LSB +: 4] = frame_err_max_i;
                end
            end
            `IRQ_STATUS_IDX: rd_byte[`IRQ_WIDTH-1:0] = irq_status;
            `IRQ_MASK_IDX:   rd_byte[`IRQ_WIDTH-1:0] = irq_mask;
            default:         rd_byte = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // bus answer
    // ---------------------------------------------------------------
    // writes to lock, count and frame error status ignored; irq status write clears the bits set in the data
    always_comb begin
        next_bus_state = fec_sync_status_pkg::BUS_IDLE;
        next_dat       = wb_dat_o;
        next_err       = 1'b0;
        case (bus_state)
            fec_sync_status_pkg::BUS_IDLE: begin
                if (req) begin
                    next_bus_state = fec_sync_status_pkg::BUS_ACK;
                    next_err       = !hit;
                    next_dat       = {24'h000000, (wb_we_i || !hit) ? 8'h00 : rd_byte};
                end
            end
            fec_sync_status_pkg::BUS_ACK: next_bus_state = fec_sync_status_pkg::BUS_IDLE;
            default:                      next_bus_state = fec_sync_status_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= fec_sync_status_pkg::BUS_IDLE;
            wb_dat_o  <= 32'h00000000;
            wb_err_o  <= 1'b0;
        end else if (ce_i) begin
            bus_state <= next_bus_state;
            wb_dat_o  <= next_dat;
            wb_err_o  <= next_err;
        end
    end

    assign wb_ack_o = (bus_state == fec_sync_status_pkg::BUS_ACK) && !wb_err_o;

endmodule : fec_sync_status_readout

//--- fec_sync_status_readout_monitor.sv
// concurrent checks on the ports of the fec status bank
`timescale 1ns/1ps
module fec_sync_status_readout_monitor #(
    parameter int COUNT_W = 12
) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        demod_mode_i,
    input wire logic [1:0]  sync_state_i,
    input wire logic [1:0]  trellis_state_i,
    input wire logic [3:0]  deint_word_i,
    input wire logic        deframer_lock_i,
    input wire logic [3:0]  frame_err_max_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [7:0] idx = wb_adr_i[9:2];
    // ------------------------------------------------------------
    // read data follows the inputs seen on the take edge
    // ------------------------------------------------------------
    a_sync_field: assert property (
        wb_ack_o && $past(idx) == 8'h41 && !$past(wb_we_i) |-> wb_dat_o[1:0] == $past(sync_state_i))
        else $error("sync state field wrong");
    a_trellis_field: assert property (
        wb_ack_o && $past(idx) == 8'h41 && !$past(wb_we_i) && $past(demod_mode_i)
        |-> wb_dat_o[7:6] == $past(trellis_state_i)) else $error("trellis field wrong");
    a_deint_field: assert property (
        wb_ack_o && $past(idx) == 8'h41 && !$past(wb_we_i) && $past(demod_mode_i)
        |-> wb_dat_o[5:2] == $past(deint_word_i)) else $error("deinterleaver field wrong");
    a_vsb_reserved_zero: assert property (
        wb_ack_o && $past(idx) == 8'h41 && !$past(demod_mode_i) |-> wb_dat_o[7:2] == 6'h00)
        else $error("vsb layout not zero above sync");
    a_deframer_layout: assert property (
        wb_ack_o && $past(idx) == 8'h45 && !$past(wb_we_i) |-> wb_dat_o[7:0] == ($past(demod_mode_i)
        ? {3'h0, $past(deframer_lock_i), $past(frame_err_max_i)} : 8'h00)) else $error("deframer reg wrong");
    a_high_nibble_zero: assert property (
        wb_ack_o && $past(idx) == 8'h44 |-> wb_dat_o[3:0] == 4'h0) else $error("count high low nibble set");
    a_write_data_zero: assert property (
        wb_ack_o && $past(wb_we_i) || wb_err_o |-> wb_dat_o == 32'h0) else $error("data on write or error");
    a_answer_next_cycle: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
        else $error("no single answer");
    a_ack_one_cycle: assert property (
        (wb_ack_o || wb_err_o) && ce_i |=> !wb_ack_o && !wb_err_o) else $error("answer longer than a cycle");
endmodule : fec_sync_status_readout_monitor

bind fec_sync_status_readout fec_sync_status_readout_monitor #(.COUNT_W(COUNT_W)) u_mon (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .demod_mode_i(demod_mode_i), .sync_state_i(sync_state_i), .trellis_state_i(trellis_state_i),
    .deint_word_i(deint_word_i), .deframer_lock_i(deframer_lock_i), .frame_err_max_i(frame_err_max_i));

//--- testbench.sv
// self-checking bench of the fec status bank
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_b, ce, cyc, stb, we, mode, lock, ack, err, irq;
    logic [9:0]  adr;
    logic [31:0] dat, q;
    logic [1:0]  sync, trel;
    logic [3:0]  dw, fem, sel, sel_req;
    logic [11:0] cnt;
    int          n_mismatch = 0;
    int          compares = 0;
    localparam logic [7:0] RO_IDX [4] = '{8'h41, 8'h43, 8'h44, 8'h45};
    localparam logic [7:0] RO_EXP [4] = '{8'h03, 8'h23, 8'h10, 8'h1c};

    fec_sync_status_readout DUT (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
        .wb_err_o(err), .demod_mode_i(mode), .sync_state_i(sync), .trellis_state_i(trel), .deint_word_i(dw),
        .seg_error_count_i(cnt), .deframer_lock_i(lock), .frame_err_max_i(fem), .irq_o(irq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task end_of_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until the edge that samples the answer
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rd, output logic e);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= sel_req;
        adr <= {idx, 2'h0};
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
        rd = q;
        e  = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1 && err !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : bus

    task rc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        bus(1'b0, idx, 8'h00, rd, e);
        chk({e, rd[30:0]}, exp);
    endtask : rc

    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        bus(1'b1, idx, d, rd, e);
        chk({e, rd[30:0]}, 32'h0);
    endtask : wr

    task t_lock_fields;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sync <= i[1:0];
            trel <= 2'(3 - i);
            dw   <= 4'(5 * i + 1);
            mode <= 1'b1;
            rc(8'h41, {24'h0, 2'(3 - i), 4'(5 * i + 1), i[1:0]});
            @(posedge clk);
            mode <= 1'b0;
            rc(8'h41, {30'h0, i[1:0]});
        end
    endtask : t_lock_fields

    task t_counts;
        @(posedge clk);
        cnt <= 12'habc;
        rc(8'h43, 32'h0);
        wr(8'h25, 8'h01);
        rc(8'h43, 32'hbc);
        rc(8'h44, 32'ha0);
        @(posedge clk);
        cnt <= 12'h123;
        wr(8'h25, 8'h00);
        rc(8'h43, 32'hbc);
        sel_req = 4'he;
        wr(8'h25, 8'h01);
        sel_req = 4'h1;
        rc(8'h43, 32'hbc);
        wr(8'h25, 8'h01);
        rc(8'h44, 32'h10);
        rc(8'h43, 32'h23);
        rc(8'h25, 32'h0);
    endtask : t_counts

    task t_deframer;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mode <= i[1];
            lock <= i[0];
            fem  <= 4'(9 + i);
            rc(8'h45, i[1] ? {27'h0, i[0], 4'(9 + i)} : 32'h0);
        end
    endtask : t_deframer

    task t_read_only;
        logic [31:0] rd;
        logic        e;
        for (int i = 0; i < 4; i++) begin
            wr(RO_IDX[i], 8'hff);
            rc(RO_IDX[i], {24'h0, RO_EXP[i]});
        end
        bus(1'b0, 8'h42, 8'h00, rd, e);
        chk({e, rd[30:0]}, 32'h80000000);
    endtask : t_read_only

    task t_irq;
        rc(8'h61, 32'h0);
        wr(8'h60, 8'h0f);
        rc(8'h60, 32'h0);
        wr(8'h25, 8'h01);
        rc(8'h60, 32'h8);
        chk({31'h0, irq}, 32'h0);
        wr(8'h61, 8'h08);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h60, 8'h08);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    // frozen clock enable holds the lock edge until it is released
    task t_clock_enable;
        wr(8'h61, 8'h01);
        @(posedge clk);
        ce   <= 1'b0;
        sync <= 2'h1;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask : t_clock_enable

    initial begin
        rst_b = 1'b0;
        ce    = 1'b1;
        sel   = 4'h0;
        sel_req = 4'h1;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 10'h000;
        dat   = 32'h0;
        mode  = 1'b0;
        sync  = 2'h0;
        trel  = 2'h0;
        dw    = 4'h0;
        cnt   = 12'h000;
        lock  = 1'b0;
        fem   = 4'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_lock_fields();
        t_counts();
        t_deframer();
        t_read_only();
        t_irq();
        t_clock_enable();
        end_of_test();
    end
endmodule : testbench
